/* File: design/transceiver_status_readback.sv */
// Function
// - ten-bit converter result split across two registers
// - receive status bit 5 shows live loss
// - bit 4 latches loss high until read
// - reading receive status clears latched loss bit unless loss is still live
// - transmit status bit 5 shows fault seen
// - transmit status bit 4 shows driver shutoff
// - registers 19 to 39 reserved, no function
// - registers 44 to 55 reserved, read-only
// - bias threshold raises fault when digital monitor
`include "status_readback_params.svh"
`default_nettype none

module transceiver_status_readback (
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  input  wire logic [5:0] addr_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic       wr_en_in,
  input  wire logic       rd_en_in,
  output var  logic [7:0] rd_data_out,
  output var  logic       irq_out,
  input  wire logic [9:0] conv_result_in,
  input  wire logic [7:0] bias_level_in,
  input  wire logic       rx_signal_loss_live_in,
  input  wire logic       tx_fault_in,
  input  wire logic       tx_driver_shutoff_in
);

  status_readback_pkg::bank_state_type state_r;
  status_readback_pkg::bank_state_type state_nxt;

  logic [9:0] conv_sync;
  logic [7:0] bias_sync;
  logic [2:0] pin_sync;
  logic       rx_signal_loss_live;
  logic       tx_fault_pin;
  logic       tx_driver_shutoff;
  logic       bias_fault;
  logic       tx_fault_seen;
  logic       rx_signal_loss_sticky;
  logic       clear_on_read;
  logic [2:0] irq_event;
  logic [2:0] irq_clear;
  logic [2:0] irq_status;
  logic [7:0] read_word;
  logic       rsvd_low_hit;
  logic       rsvd_high_hit;

  // ==========================================================
  // pin synchronisers
  // the converter word is not handshaked, so a read taken while
  // the result changes may mix two samples for one cycle
  sync_two_ff #(
    .WIDTH (10)
  ) conv_sync_inst (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .async_in  (conv_result_in),
    .sync_out  (conv_sync)
  );

  sync_two_ff #(
    .WIDTH (8)
  ) bias_sync_inst (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .async_in  (bias_level_in),
    .sync_out  (bias_sync)
  );

  sync_two_ff #(
    .WIDTH (3)
  ) pin_sync_inst (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .async_in  ({tx_driver_shutoff_in, tx_fault_in,
                 rx_signal_loss_live_in}),
    .sync_out  (pin_sync)
  );

  assign rx_signal_loss_live = pin_sync[0];
  assign tx_fault_pin        = pin_sync[1];
  assign tx_driver_shutoff   = pin_sync[2];

  // ==========================================================
  // fault sources
  // bias compare only counts when the digital monitor is chosen
  assign bias_fault = state_r.mon_select &
                      (bias_sync >= state_r.bias_thresh);
  assign tx_fault_seen = tx_fault_pin | bias_fault;

  // ==========================================================
  // latched loss flag
  assign clear_on_read = rd_en_in &&
                         (addr_in == `ADDR_RX_STATUS);

  // live level keeps setting, so a clear during loss is undone
  sticky_flag loss_sticky_inst (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .set_in    (rx_signal_loss_live),
    .clear_in  (clear_on_read),
    .flag_out  (rx_signal_loss_sticky)
  );

  // ==========================================================
  // interrupt status, write one to clear
  assign irq_event[`IRQ_LOSS_BIT] = rx_signal_loss_live &
                                    ~state_r.loss_prev;
  assign irq_event[`IRQ_FAULT_BIT] = tx_fault_seen &
                                     ~state_r.fault_prev;
  assign irq_event[`IRQ_SHUTOFF_BIT] = tx_driver_shutoff &
                                       ~state_r.shutoff_prev;

  for (genvar i = 0; i < 3; i++) begin : g_irq
    assign irq_clear[i] = wr_en_in &&
                          (addr_in == `ADDR_IRQ_STATUS) &&
                          wr_data_in[i];

    sticky_flag irq_sticky_inst (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .set_in    (irq_event[i]),
      .clear_in  (irq_clear[i]),
      .flag_out  (irq_status[i])
    );
  end

  // ==========================================================
  // read decode
  assign rsvd_low_hit  = (addr_in >= `ADDR_RSVD_LOW_FIRST) &&
                         (addr_in <= `ADDR_RSVD_LOW_LAST);
  assign rsvd_high_hit = (addr_in >= `ADDR_RSVD_HIGH_FIRST) &&
                         (addr_in <= `ADDR_RSVD_HIGH_LAST);

  always_comb begin
    read_word = `RESET_BYTE;
    case (addr_in)
      `ADDR_CONV_UPPER: begin
        read_word = conv_sync[9:2];
      end
      `ADDR_CONV_LOWER: begin
        read_word[1:0] = conv_sync[1:0];
      end
      `ADDR_RX_STATUS: begin
        read_word[`RX_LIVE_BIT]   = rx_signal_loss_live;
        read_word[`RX_STICKY_BIT] = rx_signal_loss_sticky;
      end
      `ADDR_TX_STATUS: begin
        read_word[`TX_FAULT_BIT]   = tx_fault_seen;
        read_word[`TX_SHUTOFF_BIT] = tx_driver_shutoff;
      end
      `ADDR_MON_SELECT: begin
        read_word[`MON_SELECT_BIT] = state_r.mon_select;
      end
      `ADDR_BIAS_THRESH: begin
        read_word = state_r.bias_thresh;
      end
      `ADDR_IRQ_STATUS: begin
        read_word[2:0] = irq_status;
      end
      `ADDR_IRQ_MASK: begin
        read_word[2:0] = state_r.irq_mask;
      end
      default: begin
        read_word = `RESET_BYTE;
      end
    endcase
  end

  // ==========================================================
  // bank state
  always_comb begin
    state_nxt = state_r;
    // read data stands for one cycle only, zero otherwise
    state_nxt.rd_data = rd_en_in ? read_word : `RESET_BYTE;
    state_nxt.irq = |(irq_status & state_r.irq_mask);
    state_nxt.loss_prev    = rx_signal_loss_live;
    state_nxt.fault_prev   = tx_fault_seen;
    state_nxt.shutoff_prev = tx_driver_shutoff;
    // writes to read-only and reserved addresses are dropped
    if (wr_en_in) begin
      case (addr_in)
        `ADDR_MON_SELECT: begin
          state_nxt.mon_select = wr_data_in[`MON_SELECT_BIT];
        end
        `ADDR_BIAS_THRESH: begin
          state_nxt.bias_thresh = wr_data_in;
        end
        `ADDR_IRQ_MASK: begin
          state_nxt.irq_mask = wr_data_in[2:0];
        end
        default: begin
          state_nxt.mon_select = state_r.mon_select;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r.rd_data      <= `RESET_BYTE;
      state_r.irq          <= 1'b0;
      state_r.bias_thresh  <= `RESET_BYTE;
      state_r.mon_select   <= `RESET_MON_SELECT;
      state_r.irq_mask     <= `RESET_IRQ_MASK;
      state_r.loss_prev    <= 1'b0;
      state_r.fault_prev   <= 1'b0;
      state_r.shutoff_prev <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rd_data_out = state_r.rd_data;
  assign irq_out     = state_r.irq;

  // ==========================================================
  // checks
  conv_upper_read_a : assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    rd_en_in && addr_in == `ADDR_CONV_UPPER
    |=> rd_data_out == $past(conv_sync[9:2]))
    else $error("converter upper byte read wrong");

  conv_lower_read_a : assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    rd_en_in && addr_in == `ADDR_CONV_LOWER
    |=> rd_data_out == {6'h00, $past(conv_sync[1:0])})
    else $error("converter lower byte read wrong");

  rx_live_bit_a : assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    clear_on_read
    |=> rd_data_out[`RX_LIVE_BIT] == $past(rx_signal_loss_live))
    else $error("live loss bit read wrong");

  rx_sticky_hold_a : assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    rx_signal_loss_live ##1 !clear_on_read [*2]
    |-> rx_signal_loss_sticky)
    else $error("latched loss bit not held");

  rx_sticky_clear_a : assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    clear_on_read && !rx_signal_loss_live
    |=> !rx_signal_loss_sticky)
    else $error("latched loss bit not cleared by read");

  rx_reserved_zero_a : assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    clear_on_read
    |=> rd_data_out[7:6] == 2'h0 && rd_data_out[3:0] == 4'h0)
    else $error("receive status reserved bits not zero");

  tx_fault_bit_a : assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    rd_en_in && addr_in == `ADDR_TX_STATUS
    |=> rd_data_out[`TX_FAULT_BIT] == $past(tx_fault_seen))
    else $error("transmit fault bit read wrong");

  tx_shutoff_bit_a : assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    rd_en_in && addr_in == `ADDR_TX_STATUS
    |=> rd_data_out[`TX_SHUTOFF_BIT] == $past(tx_driver_shutoff))
    else $error("driver shutoff bit read wrong");

  rsvd_low_zero_a : assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    rd_en_in && rsvd_low_hit |=> rd_data_out == 8'h00)
    else $error("low reserved block read not zero");

  rsvd_high_zero_a : assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    rd_en_in && rsvd_high_hit |=> rd_data_out == 8'h00)
    else $error("high reserved block read not zero");

  bias_fault_raise_a : assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    rd_en_in && addr_in == `ADDR_TX_STATUS && state_r.mon_select &&
    bias_sync >= state_r.bias_thresh
    |=> rd_data_out[`TX_FAULT_BIT])
    else $error("bias threshold did not raise fault");

  sticky_rearm_a : assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    clear_on_read && rx_signal_loss_live
    |=> rx_signal_loss_sticky)
    else $error("loss event lost at read clear");

  irq_level_a : assert property (
    @(posedge clk_in) disable iff (!arst_n_in)
    ##1 irq_out == $past(|(irq_status & state_r.irq_mask)))
    else $error("interrupt level does not follow status");

endmodule

`default_nettype wire

/* File: design/status_readback_params.svh */
`ifndef STATUS_READBACK_PARAMS_SVH
`define STATUS_READBACK_PARAMS_SVH

// ==========================================================
// register addresses (register number on the management port)
`define ADDR_MON_SELECT      6'h10
`define ADDR_BIAS_THRESH     6'h11
`define ADDR_RSVD_LOW_FIRST  6'h13
`define ADDR_RSVD_LOW_LAST   6'h27
`define ADDR_CONV_UPPER      6'h28
`define ADDR_CONV_LOWER      6'h29
`define ADDR_RX_STATUS       6'h2a
`define ADDR_TX_STATUS       6'h2b
`define ADDR_RSVD_HIGH_FIRST 6'h2c
`define ADDR_RSVD_HIGH_LAST  6'h37
`define ADDR_IRQ_STATUS      6'h38
`define ADDR_IRQ_MASK        6'h39

// ==========================================================
// field positions
`define RX_LIVE_BIT          5
`define RX_STICKY_BIT        4
`define TX_FAULT_BIT         5
`define TX_SHUTOFF_BIT       4
`define MON_SELECT_BIT       5
`define IRQ_LOSS_BIT         0
`define IRQ_FAULT_BIT        1
`define IRQ_SHUTOFF_BIT      2

// ==========================================================
// reset values
`define RESET_BYTE           8'h00
`define RESET_IRQ_MASK       3'h0
`define RESET_MON_SELECT     1'h0

`endif

/* File: design/status_readback_pkg.sv */
`default_nettype none

package status_readback_pkg;

  // ========================================================
  // state of one sticky flag
  typedef struct packed {
    logic flag;
  } sticky_state_type;

  // ========================================================
  // state of the register bank
  typedef struct packed {
    logic [7:0] rd_data;
    logic       irq;
    logic [7:0] bias_thresh;
    logic       mon_select;
    logic [2:0] irq_mask;
    logic       loss_prev;
    logic       fault_prev;
    logic       shutoff_prev;
  } bank_state_type;

endpackage

`default_nettype wire

/* File: design/sync_two_ff.sv */
`default_nettype none

module sync_two_ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             arst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_type;

  sync_state_type state_r;
  sync_state_type state_nxt;

  // ========================================================
  // stage1 feeds stage2 only
  always_comb begin
    state_nxt.stage1 = async_in;
    state_nxt.stage2 = state_r.stage1;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign sync_out = state_r.stage2;

endmodule

`default_nettype wire

/* File: design/sticky_flag.sv */
`default_nettype none

module sticky_flag (
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic set_in,
  input  wire logic clear_in,
  output var  logic flag_out
);

  status_readback_pkg::sticky_state_type state_r;
  status_readback_pkg::sticky_state_type state_nxt;

  // ========================================================
  // set beats clear so an event in the clear cycle survives
  always_comb begin
    state_nxt.flag = set_in | (state_r.flag & ~clear_in);
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign flag_out = state_r.flag;

endmodule

`default_nettype wire

/* File: verification/host_model.sv */
`default_nettype none

// ==========================================================
// management host: one strobe per access, bus scrambled when idle
module host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] rd_data_in,
  output var  logic [5:0] addr_out,
  output var  logic [7:0] wr_data_out,
  output var  logic       wr_en_out,
  output var  logic       rd_en_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    addr_out = 6'h00;
    wr_data_out = 8'h00;
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
  end

  // idle cycle after each strobe so no signal is driven twice per step
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    wr_en_out <= 1'b1;
    addr_out <= a;
    wr_data_out <= d;
    @(posedge clk_in);
    wr_en_out <= 1'b0;
    addr_out <= ~a;
    wr_data_out <= ~d;
    @(posedge clk_in);
  endtask

  // data are taken at the edge that ends the cycle after the strobe
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    rd_en_out <= 1'b1;
    addr_out <= a;
    @(posedge clk_in);
    rd_en_out <= 1'b0;
    addr_out <= ~a;
    @(posedge clk_in);
    d = rd_data_in;
  endtask
endmodule

`default_nettype wire

/* File: verification/transceiver_status_readback_bench.sv */
`default_nettype none

module transceiver_status_readback_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [5:0] addr;
  logic [7:0] wr_data;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] rd_data;
  logic       irq;
  logic [9:0] conv = 10'h000;
  logic [7:0] bias = 8'h00;
  logic       loss = 1'b0;
  logic       fault = 1'b0;
  logic       shutoff = 1'b0;
  int         n_fail = 0;
  int         checked = 0;

  always #2 clk = ~clk;

  transceiver_status_readback transceiver_status_readback_i (
    .clk_in                 (clk),
    .arst_n_in              (arst_n),
    .addr_in                (addr),
    .wr_data_in             (wr_data),
    .wr_en_in               (wr_en),
    .rd_en_in               (rd_en),
    .rd_data_out            (rd_data),
    .irq_out                (irq),
    .conv_result_in         (conv),
    .bias_level_in          (bias),
    .rx_signal_loss_live_in (loss),
    .tx_fault_in            (fault),
    .tx_driver_shutoff_in   (shutoff)
  );

  host_model host_model_i (
    .clk_in      (clk),
    .rd_data_in  (rd_data),
    .addr_out    (addr),
    .wr_data_out (wr_data),
    .wr_en_out   (wr_en),
    .rd_en_out   (rd_en)
  );

  // ==========================================================
  // helpers
  task automatic end_sim();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_model_i.rd(a, d);
    check(d, exp);
  endtask

  // five edges cover the synchroniser, the event flag and the irq register
  task automatic pins(input logic l, input logic f, input logic s);
    loss <= l;
    fault <= f;
    shutoff <= s;
    repeat (5) @(posedge clk);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [5:0] regs [8];
    regs = '{6'h10, 6'h11, 6'h28, 6'h29, 6'h2a, 6'h2b, 6'h38, 6'h39};
    foreach (regs[k])
      rchk(regs[k], 8'h00);
  endtask

  task automatic t_conv();
    conv <= 10'h2b5;
    repeat (3) @(posedge clk);
    host_model_i.wr(6'h28, 8'h5a);
    rchk(6'h28, 8'had);
    rchk(6'h29, 8'h01);
    conv <= 10'h3ff;
    repeat (3) @(posedge clk);
    rchk(6'h28, 8'hff);
    rchk(6'h29, 8'h03);
  endtask

  task automatic t_loss();
    pins(1'b1, 1'b0, 1'b0);
    rchk(6'h2a, 8'h30);
    rchk(6'h2a, 8'h30);
    pins(1'b0, 1'b0, 1'b0);
    rchk(6'h2a, 8'h10);
    rchk(6'h2a, 8'h00);
    loss <= 1'b1;
    @(posedge clk);
    pins(1'b0, 1'b0, 1'b0);
    rchk(6'h2a, 8'h10);
    rchk(6'h2a, 8'h00);
  endtask

  task automatic t_tx();
    pins(1'b0, 1'b1, 1'b0);
    rchk(6'h2b, 8'h20);
    pins(1'b0, 1'b0, 1'b1);
    rchk(6'h2b, 8'h10);
    pins(1'b0, 1'b0, 1'b0);
    rchk(6'h2b, 8'h00);
  endtask

  task automatic t_bias();
    bias <= 8'h80;
    host_model_i.wr(6'h11, 8'h80);
    rchk(6'h11, 8'h80);
    rchk(6'h2b, 8'h00);
    host_model_i.wr(6'h10, 8'hff);
    rchk(6'h10, 8'h20);
    rchk(6'h2b, 8'h20);
    host_model_i.wr(6'h11, 8'h81);
    rchk(6'h2b, 8'h00);
    host_model_i.wr(6'h10, 8'h00);
  endtask

  task automatic t_irq();
    host_model_i.wr(6'h38, 8'h07);
    host_model_i.wr(6'h39, 8'h01);
    rchk(6'h39, 8'h01);
    check({7'h00, irq}, 8'h00);
    pins(1'b0, 1'b1, 1'b0);
    check({7'h00, irq}, 8'h00);
    rchk(6'h38, 8'h02);
    pins(1'b1, 1'b1, 1'b0);
    check({7'h00, irq}, 8'h01);
    pins(1'b0, 1'b0, 1'b0);
    host_model_i.wr(6'h38, 8'h07);
    @(posedge clk);
    check({7'h00, irq}, 8'h00);
    rchk(6'h38, 8'h00);
    // shutoff event and its mask bit were otherwise never observed
    pins(1'b0, 1'b0, 1'b1);
    rchk(6'h38, 8'h04);
    host_model_i.wr(6'h39, 8'h04);
    @(posedge clk);
    check({7'h00, irq}, 8'h01);
    pins(1'b0, 1'b0, 1'b0);
    host_model_i.wr(6'h38, 8'h07);
    @(posedge clk);
    check({7'h00, irq}, 8'h00);
  endtask

  // writes to reserved places must leave nothing readable behind
  task automatic t_rsvd();
    for (int i = 'h13; i <= 'h37; i++) begin
      if (i < 'h28 || i > 'h2b) begin
        host_model_i.wr(i[5:0], 8'hff);
        rchk(i[5:0], 8'h00);
      end
    end
    rchk(6'h3f, 8'h00);
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_conv();
    t_loss();
    t_tx();
    t_bias();
    t_irq();
    t_rsvd();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_sim();
  end
endmodule

`default_nettype wire
